// ---- periph_pins_model.sv ----
// Model of the peripherals, port logic and pads around the block.
// Assumes the bench sets the static levels through parameters.
`timescale 1ns/1ps
module periph_pins_model #(
  parameter logic [31:0] OUT_PAT  = 32'h0000_0000,
  parameter logic [25:0] PORT_PAT = 26'h000_0000,
  parameter logic [25:0] PIN_PAT  = 26'h000_0000
) (
  output logic [31:0] periph_out,
  output logic [25:0] port_out,
  output logic [25:0] pin_in
);
  assign periph_out = OUT_PAT;
  assign port_out   = PORT_PAT;
  assign pin_in     = PIN_PAT; // Pads set as inputs
endmodule

// ---- pps_in_sel.sv ----
// One peripheral input selector.
// Assumes pin levels are already synchronised to the system clock.
`timescale 1ns/1ps
module pps_in_sel #(
  parameter int NPINS = 26
) (
  input  wire logic [4:0]       sel,
  input  wire logic [NPINS-1:0] pin_in,
  output logic                  periph_in
);

  localparam logic [4:0] PIN_LIMIT = 5'(NPINS);

  // ----------------------------------------------------------------
  // Route pin or tie to ground
  // ----------------------------------------------------------------
  always_comb begin
    if (sel < PIN_LIMIT) begin
      periph_in = pin_in[sel];
    end else begin
      periph_in = 1'b0;
    end
  end

endmodule

// ---- pps_out_sel.sv ----
// One remappable pin output selector.
// Assumes peripheral outputs arrive indexed by their select code.
`timescale 1ns/1ps
module pps_out_sel #(
  parameter int NCODES = 32
) (
  input  wire logic [4:0]        sel,
  input  wire logic [NCODES-1:0] periph_out,
  input  wire logic [NCODES-1:0] code_valid,
  input  wire logic              port_out,
  output logic                   pin_out
);

  // ----------------------------------------------------------------
  // Select peripheral or port logic
  // ----------------------------------------------------------------
  always_comb begin
    if (code_valid[sel]) begin
      pin_out = periph_out[sel];
    end else begin
      pin_out = port_out;
    end
  end

endmodule

// ---- pps_pkg.sv ----
// Constants, types and register map for the remappable pin select block.
// Assumes a 32-bit Avalon-MM slave port with byte addressing.
package pps_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PINS     = 26;
  localparam int NUM_IN_REGS  = 16;
  localparam int NUM_OUT_REGS = 13;
  localparam int NUM_PERIPH_IN = 2 * NUM_IN_REGS;
  localparam int SEL_W        = 5;
  localparam int NUM_CODES    = 32;
  localparam int ADDR_W       = 8;
  localparam int DATA_W       = 32;
  localparam int IRQ_W        = 3;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_OSC       = 8'h00;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h08;
  localparam logic [7:0] OFS_LOCK_INFO = 8'h0C;
  localparam logic [7:0] OFS_IN_BASE   = 8'h40;
  localparam logic [7:0] OFS_OUT_BASE  = 8'h80;
  localparam logic [7:0] OFS_BANK_MASK = 8'hC0;

  // ----------------------------------------------------------------
  // Field positions and key values
  // ----------------------------------------------------------------
  localparam int LOCK_BIT = 6;
  localparam int HI_LSB   = 8;
  localparam int LO_LSB   = 0;
  localparam logic [7:0] KEY_FIRST  = 8'h46;
  localparam logic [7:0] KEY_SECOND = 8'h57;
  localparam int IRQ_MISMATCH  = 0;
  localparam int IRQ_LOCKED_WR = 1;
  localparam int IRQ_LOCK_CHG  = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] IN_TIE_GROUND = 5'h1F;
  localparam logic [4:0] OUT_SEL_NULL  = 5'h00;
  localparam logic       LOCK_RESET    = 1'b0;

  // ----------------------------------------------------------------
  // Output select codes
  // ----------------------------------------------------------------
  localparam logic [4:0] CODE_COMPARATOR_ONE_OUT     = 5'h01;
  localparam logic [4:0] CODE_COMPARATOR_TWO_OUT     = 5'h02;
  localparam logic [4:0] CODE_UART_ONE_TRANSMIT      = 5'h03;
  localparam logic [4:0] CODE_UART_ONE_REQ_TO_SEND   = 5'h04;
  localparam logic [4:0] CODE_UART_TWO_TRANSMIT      = 5'h05;
  localparam logic [4:0] CODE_UART_TWO_REQ_TO_SEND   = 5'h06;
  localparam logic [4:0] CODE_SPI_ONE_DATA_OUT       = 5'h07;
  localparam logic [4:0] CODE_SPI_ONE_CLOCK_OUT      = 5'h08;
  localparam logic [4:0] CODE_SPI_ONE_SELECT_OUT     = 5'h09;
  localparam logic [4:0] CODE_SPI_TWO_DATA_OUT       = 5'h0A;
  localparam logic [4:0] CODE_SPI_TWO_CLOCK_OUT      = 5'h0B;
  localparam logic [4:0] CODE_SPI_TWO_SELECT_OUT     = 5'h0C;
  localparam logic [4:0] CODE_CODEC_SERIAL_DATA_OUT  = 5'h0D;
  localparam logic [4:0] CODE_CODEC_SERIAL_CLOCK_OUT = 5'h0E;
  localparam logic [4:0] CODE_CODEC_FRAME_SYNC_OUT   = 5'h0F;
  localparam logic [4:0] CODE_CAN_TRANSMIT           = 5'h10;
  localparam logic [4:0] CODE_COMPARE_OUTPUT_ONE     = 5'h12;
  localparam logic [4:0] CODE_COMPARE_OUTPUT_TWO     = 5'h13;
  localparam logic [4:0] CODE_COMPARE_OUTPUT_THREE   = 5'h14;
  localparam logic [4:0] CODE_COMPARE_OUTPUT_FOUR    = 5'h15;
  localparam logic [4:0] CODE_UNASSIGNED_GAP         = 5'h11;
  // One bit per assigned code: 01..10 and 12..15
  localparam logic [31:0] OUT_CODE_VALID = 32'h003DFFFE;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] hi;
    logic [4:0] lo;
  } sel_pair_t;

  localparam sel_pair_t IN_PAIR_RESET  = '{hi: IN_TIE_GROUND, lo: IN_TIE_GROUND};
  localparam sel_pair_t OUT_PAIR_RESET = '{hi: OUT_SEL_NULL, lo: OUT_SEL_NULL};

  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_OPEN} key_state_t;

endpackage

// ---- remappable_pin_select.sv ----
// Remappable pin select: output and input maps, lock, shadow monitor.
// Assumes an Avalon-MM master on REF_CLK and peripherals on the same clock.
//
// Overview of operation
// - Each remappable pin has its own 5-bit output select field choosing its driver.
// - A select code of zero leaves the pin on its ordinary port logic.
// - Codes 01 to 09 select comparators, both UARTs and the first SPI outputs.
// - Codes 0A to 10 and 12 to 15 select second SPI, codec, CAN and compare outputs.
// - While the map lock is set, select register writes complete but change nothing.
// - The map lock is bit 6 of the oscillator control register.
// - The lock changes only on the write that follows the keys 46 then 57 in the low byte.
// - The map lock keeps its value until software changes it.
// - Shadow copies of all select registers are compared and a mismatch raises a reset.
// - With the one-way option set, a lock once set cannot be cleared before reset.
// - The one-way option input is high when unprogrammed, allowing one session.
// - There are 16 input select and 13 output select registers.
// - The first input register holds the interrupt one selector in bits 12 to 8, reset ones.
// - Input code 1F ties the peripheral input low; codes 00 to 19 pick that pin.
// - Writing an input selector routes the numbered pin to that peripheral input.
`timescale 1ns/1ps
module remappable_pin_select (
  input  wire logic                               REF_CLK,
  input  wire logic                               ARST_N,
  input  wire logic [pps_pkg::ADDR_W-1:0]         AVS_ADDRESS,
  input  wire logic                               AVS_READ,
  input  wire logic                               AVS_WRITE,
  input  wire logic [pps_pkg::DATA_W-1:0]         AVS_WRITEDATA,
  input  wire logic [3:0]                         AVS_BYTEENABLE,
  output logic      [pps_pkg::DATA_W-1:0]         AVS_READDATA,
  output logic                                    AVS_WAITREQUEST,
  output logic                                    IRQ,
  input  wire logic                               ONE_SHOT_LOCK_CONFIG,
  input  wire logic [pps_pkg::NUM_CODES-1:0]      PERIPH_OUT,
  input  wire logic [pps_pkg::NUM_PINS-1:0]       PORT_OUT,
  input  wire logic [pps_pkg::NUM_PINS-1:0]       PIN_IN,
  output logic      [pps_pkg::NUM_PINS-1:0]       PIN_OUT,
  output logic      [pps_pkg::NUM_PERIPH_IN-1:0]  PERIPH_IN,
  output logic                                    MAP_WRITE_LOCK,
  output logic                                    CFG_MISMATCH_RESET
);
  import pps_pkg::*;

  localparam logic [3:0] OUT_IDX_LIMIT = 4'(NUM_OUT_REGS);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                      ack_ff;
  logic [DATA_W-1:0]         readdata_ff;
  key_state_t                key_ff;
  logic                      lock_ff;
  logic                      set_once_ff;
  logic                      mismatch_ff;
  logic [IRQ_W-1:0]          irq_stat_ff;
  logic [IRQ_W-1:0]          irq_mask_ff;
  sel_pair_t                 in_sel_ff  [NUM_IN_REGS];
  sel_pair_t                 in_shd_ff  [NUM_IN_REGS];
  sel_pair_t                 out_sel_ff [NUM_OUT_REGS];
  sel_pair_t                 out_shd_ff [NUM_OUT_REGS];
  logic [NUM_PINS-1:0]       pin_meta_ff;
  logic [NUM_PINS-1:0]       pin_sync_ff;
  logic                      req;
  logic                      wr_take;
  logic                      osc_wr;
  logic                      in_hit;
  logic                      out_hit;
  logic [3:0]                reg_idx;
  logic                      sel_wr;
  logic                      sel_wr_ok;
  logic                      locked_ev;
  logic                      key_open_wr;
  logic                      one_way_block;
  logic                      nxt_lock;
  logic                      lock_chg;
  logic                      diff;
  logic [IRQ_W-1:0]          irq_set;
  logic [IRQ_W-1:0]          irq_w1c;
  logic [DATA_W-1:0]         rd_mux;

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle per access
  // ----------------------------------------------------------------
  assign req             = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_ff;
  assign wr_take         = AVS_WRITE & ack_ff;
  assign AVS_READDATA    = readdata_ff;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_ff      <= 1'b0;
      readdata_ff <= '0;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (AVS_READ && !ack_ff) begin
        readdata_ff <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign reg_idx  = AVS_ADDRESS[5:2];
  assign in_hit   = (AVS_ADDRESS & OFS_BANK_MASK) == OFS_IN_BASE;
  assign out_hit  = ((AVS_ADDRESS & OFS_BANK_MASK) == OFS_OUT_BASE)
                    && (reg_idx < OUT_IDX_LIMIT);
  assign osc_wr   = wr_take && (AVS_ADDRESS == OFS_OSC) && AVS_BYTEENABLE[0];
  assign sel_wr    = wr_take & (in_hit | out_hit);
  assign sel_wr_ok = sel_wr & ~lock_ff;
  assign locked_ev = sel_wr & lock_ff;

  always_comb begin
    rd_mux = '0;
    if (in_hit) begin
      rd_mux[HI_LSB +: SEL_W] = in_sel_ff[reg_idx].hi;
      if (reg_idx != 4'h0) begin
        rd_mux[LO_LSB +: SEL_W] = in_sel_ff[reg_idx].lo;
      end
    end else if (out_hit) begin
      rd_mux[HI_LSB +: SEL_W] = out_sel_ff[reg_idx].hi;
      rd_mux[LO_LSB +: SEL_W] = out_sel_ff[reg_idx].lo;
    end else begin
      unique case (AVS_ADDRESS)
        OFS_OSC:       rd_mux[LOCK_BIT] = lock_ff;
        OFS_IRQ_STAT:  rd_mux[IRQ_W-1:0] = irq_stat_ff;
        OFS_IRQ_MASK:  rd_mux[IRQ_W-1:0] = irq_mask_ff;
        OFS_LOCK_INFO: rd_mux[1:0] = {set_once_ff, ONE_SHOT_LOCK_CONFIG};
        default:       rd_mux = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Unlock key sequence
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      key_ff <= KEY_IDLE;
    end else if (osc_wr) begin
      unique case (key_ff)
        KEY_IDLE: key_ff <= (AVS_WRITEDATA[7:0] == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
        KEY_HALF: key_ff <= (AVS_WRITEDATA[7:0] == KEY_SECOND) ? KEY_OPEN : KEY_IDLE;
        KEY_OPEN: key_ff <= KEY_IDLE;
        default:  key_ff <= KEY_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Map write lock
  // ----------------------------------------------------------------
  assign key_open_wr   = osc_wr && (key_ff == KEY_OPEN);
  assign one_way_block = ONE_SHOT_LOCK_CONFIG & set_once_ff;
  assign nxt_lock      = (!AVS_WRITEDATA[LOCK_BIT] && one_way_block) ? lock_ff
                         : AVS_WRITEDATA[LOCK_BIT];
  assign lock_chg      = key_open_wr && (nxt_lock != lock_ff);
  assign MAP_WRITE_LOCK = lock_ff;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lock_ff <= LOCK_RESET;
    end else if (key_open_wr) begin
      lock_ff <= nxt_lock;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      set_once_ff <= 1'b0;
    end else if (lock_ff) begin
      set_once_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Select registers and their shadows
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < NUM_IN_REGS; i++) begin
        in_sel_ff[i] <= IN_PAIR_RESET;
        in_shd_ff[i] <= IN_PAIR_RESET;
      end
    end else if (sel_wr_ok && in_hit) begin
      if (AVS_BYTEENABLE[1]) begin
        in_sel_ff[reg_idx].hi <= AVS_WRITEDATA[HI_LSB +: SEL_W];
        in_shd_ff[reg_idx].hi <= AVS_WRITEDATA[HI_LSB +: SEL_W];
      end
      if (AVS_BYTEENABLE[0] && reg_idx != 4'h0) begin
        in_sel_ff[reg_idx].lo <= AVS_WRITEDATA[LO_LSB +: SEL_W];
        in_shd_ff[reg_idx].lo <= AVS_WRITEDATA[LO_LSB +: SEL_W];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < NUM_OUT_REGS; i++) begin
        out_sel_ff[i] <= OUT_PAIR_RESET;
        out_shd_ff[i] <= OUT_PAIR_RESET;
      end
    end else if (sel_wr_ok && out_hit) begin
      if (AVS_BYTEENABLE[1]) begin
        out_sel_ff[reg_idx].hi <= AVS_WRITEDATA[HI_LSB +: SEL_W];
        out_shd_ff[reg_idx].hi <= AVS_WRITEDATA[HI_LSB +: SEL_W];
      end
      if (AVS_BYTEENABLE[0]) begin
        out_sel_ff[reg_idx].lo <= AVS_WRITEDATA[LO_LSB +: SEL_W];
        out_shd_ff[reg_idx].lo <= AVS_WRITEDATA[LO_LSB +: SEL_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // Shadow monitor
  // ----------------------------------------------------------------
  assign diff = (in_sel_ff != in_shd_ff) || (out_sel_ff != out_shd_ff);
  assign CFG_MISMATCH_RESET = mismatch_ff;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mismatch_ff <= 1'b0;
    end else begin
      mismatch_ff <= diff;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts: sticky status, write one to clear, set wins
  // ----------------------------------------------------------------
  assign irq_set = {lock_chg, locked_ev, diff};

  assign irq_w1c = (wr_take && AVS_ADDRESS == OFS_IRQ_STAT && AVS_BYTEENABLE[0])
                   ? AVS_WRITEDATA[IRQ_W-1:0] : '0;
  assign IRQ = |(irq_stat_ff & irq_mask_ff);

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_w1c) | irq_set;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_mask_ff <= '0;
    end else if (wr_take && AVS_ADDRESS == OFS_IRQ_MASK && AVS_BYTEENABLE[0]) begin
      irq_mask_ff <= AVS_WRITEDATA[IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= PIN_IN;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Selector instances
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_out
    pps_out_sel #(.NCODES(NUM_CODES)) u_out (
      .sel        ((p % 2 == 1) ? out_sel_ff[p/2].hi : out_sel_ff[p/2].lo),
      .periph_out (PERIPH_OUT),
      .code_valid (OUT_CODE_VALID),
      .port_out   (PORT_OUT[p]),
      .pin_out    (PIN_OUT[p])
    );
  end

  for (genvar k = 0; k < NUM_PERIPH_IN; k++) begin : g_in
    pps_in_sel #(.NPINS(NUM_PINS)) u_in (
      .sel       ((k % 2 == 1) ? in_sel_ff[k/2].hi : in_sel_ff[k/2].lo),
      .pin_in    (pin_sync_ff),
      .periph_in (PERIPH_IN[k])
    );
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_null_port_pass: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (out_sel_ff[0].lo == OUT_SEL_NULL) |-> (PIN_OUT[0] == PORT_OUT[0]))
    else $error("null code does not pass port logic");
  a_uart_code_route: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (out_sel_ff[0].lo == CODE_UART_ONE_TRANSMIT) |-> (PIN_OUT[0] == PERIPH_OUT[3]))
    else $error("uart transmit code misrouted");
  a_compare_code_route: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (out_sel_ff[0].hi == CODE_COMPARE_OUTPUT_FOUR) |-> (PIN_OUT[1] == PERIPH_OUT[21]))
    else $error("compare four code misrouted");
  a_gap_code_null: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (out_sel_ff[0].lo == CODE_UNASSIGNED_GAP) |-> (PIN_OUT[0] == PORT_OUT[0]))
    else $error("unassigned code drives pin");
  a_locked_write_kept: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (locked_ev && in_hit && reg_idx == 4'h0) |=> $stable(in_sel_ff[0]))
    else $error("locked write changed an input select");
  a_lock_after_key: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    $changed(lock_ff) |-> ($past(key_ff) == KEY_OPEN && $past(osc_wr)))
    else $error("lock changed without key sequence");
  a_lock_holds: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (!key_open_wr) |=> $stable(lock_ff))
    else $error("lock changed by itself");
  a_one_way_hold: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (ONE_SHOT_LOCK_CONFIG && set_once_ff && lock_ff) |=> lock_ff)
    else $error("one-way lock was cleared");
  a_mismatch_reset: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    diff |=> (CFG_MISMATCH_RESET && irq_stat_ff[IRQ_MISMATCH]))
    else $error("shadow mismatch not flagged");
  a_external_interrupt_one_low_zero: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (AVS_READ && !ack_ff && in_hit && reg_idx == 4'h0) |=> (AVS_READDATA[7:0] == 8'h00))
    else $error("first input register low bits not zero");
  a_ground_tie: assert property (
    @(posedge REF_CLK) disable iff (!ARST_N)
    (in_sel_ff[0].hi == IN_TIE_GROUND) |-> (PERIPH_IN[1] == 1'b0))
    else $error("ground code does not tie input low");

endmodule

// ---- remappable_pin_select_test.sv ----
// Bench for the remappable pin select block.
// Assumes pps_pkg, the design and the pad model are compiled first.
`timescale 1ns/1ps
module remappable_pin_select_test;
  import pps_pkg::*;
  localparam logic [31:0] OP = 32'h5A3C_96E1;
  localparam logic [25:0] PP = 26'h155_5555;
  localparam logic [25:0] NP = 26'h000_0020;
  logic        clk = 1'b0, arst_n = 1'b0, rd = 1'b0, wr = 1'b0, opt = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, pout, per_in;
  logic [25:0] port, pin, pin_out;
  logic        wait_q, irq, lock, mis;
  int          mismatches = 0, num_checks = 0;
  always #5 clk = ~clk;
  periph_pins_model #(.OUT_PAT(OP), .PORT_PAT(PP), .PIN_PAT(NP)) periph_pins_model_inst (
    .periph_out(pout), .port_out(port), .pin_in(pin));
  remappable_pin_select remappable_pin_select_inst (
    .REF_CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'h3), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wait_q), .IRQ(irq), .ONE_SHOT_LOCK_CONFIG(opt), .PERIPH_OUT(pout),
    .PORT_OUT(port), .PIN_IN(pin), .PIN_OUT(pin_out), .PERIPH_IN(per_in),
    .MAP_WRITE_LOCK(lock), .CFG_MISMATCH_RESET(mis));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_q !== 1'b0 && n < 50);
    if (n >= 50) mismatches++;
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr32(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(string nm, logic [7:0] a, logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic do_reset(logic o);
    opt <= o;
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rchk("in0", OFS_IN_BASE, 32'h0000_1F00);
    rchk("in1", OFS_IN_BASE + 8'h04, 32'h0000_1F1F);
    chk("pin_rst", {6'h00, pin_out}, {6'h00, PP});
    chk("external_interrupt_one_rst", {31'h0, per_in[1]}, 32'h0);
  endtask
  task automatic t_codes;
    logic e;
    for (int c = 0; c < 32; c++) begin
      wr32(OFS_OUT_BASE, 32'(c));
      e = (c != 0 && c != 17 && c < 22) ? OP[c] : PP[0];
      chk("pin0", {31'h0, pin_out[0]}, {31'h0, e});
    end
    wr32(OFS_OUT_BASE + 8'h30, 32'h0000_0300);
    chk("pin25", {31'h0, pin_out[25]}, {31'h0, OP[3]});
    rchk("out13", OFS_OUT_BASE + 8'h34, 32'h0);
  endtask
  task automatic t_input;
    wr32(OFS_IN_BASE, 32'h0000_0500);
    repeat (4) @(posedge clk);
    chk("external_interrupt_one_p5", {31'h0, per_in[1]}, {31'h0, NP[5]});
    wr32(OFS_IN_BASE, 32'h0000_1F00);
    repeat (4) @(posedge clk);
    chk("external_interrupt_one_gnd", {31'h0, per_in[1]}, 32'h0);
  endtask
  task automatic t_lock;
    wr32(OFS_IRQ_MASK, 32'h2);
    wr32(OFS_OUT_BASE, 32'h7);
    wr32(OFS_OSC, 32'h46);
    wr32(OFS_OSC, 32'h00);
    wr32(OFS_OSC, 32'h40);
    chk("bad_key", {31'h0, lock}, 32'h0);
    wr32(OFS_OSC, 32'h46);
    wr32(OFS_OSC, 32'h57);
    wr32(OFS_IN_BASE + 8'h04, 32'h0);
    wr32(OFS_OSC, 32'h40);
    rchk("osc", OFS_OSC, 32'h40);
    rchk("stat_chg", OFS_IRQ_STAT, 32'h4);
    rchk("info", OFS_LOCK_INFO, opt ? 32'h3 : 32'h2);
    chk("irq_idle", {31'h0, irq}, 32'h0);
    wr32(OFS_OUT_BASE, 32'h3);
    rchk("out0_lk", OFS_OUT_BASE, 32'h7);
    wr32(OFS_IN_BASE, 32'h0000_0300);
    rchk("in0_lk", OFS_IN_BASE, 32'h0000_1F00);
    chk("irq_set", {31'h0, irq}, 32'h1);
    wr32(OFS_IRQ_STAT, 32'h2);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    wr32(OFS_OSC, 32'h46);
    wr32(OFS_OSC, 32'h57);
    wr32(OFS_OSC, 32'h00);
    chk("unlock", {31'h0, lock}, {31'h0, opt});
    wr32(OFS_OUT_BASE, 32'h3);
    wr32(OFS_OUT_BASE + 8'h04, 32'h3);
    rchk("out0_ul", OFS_OUT_BASE, opt ? 32'h7 : 32'h3);
    chk("mismatch", {31'h0, mis}, 32'h0);
  endtask
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    do_reset(1'b1);
    t_reset;
    t_codes;
    t_input;
    t_lock;
    do_reset(1'b0);
    t_lock;
    give_verdict;
  end
  // Run needs about 275 cycles; watchdog allows far more
  initial begin
    #200000;
    mismatches++;
    give_verdict;
  end
endmodule
